/* src/amnc_top.sv */
// Contract
// - filter width select in bits 7..4
// - hysteresis select in bits 3..0
// - zero hysteresis select bypasses buffer
// - priority decode: bit3 wide, bit2 middle
// - hysteresis select resets to zero
// - short pulses never reach the counter
// - set-bit count picks 5..80 ns width
// - filter select resets to 1000
// - vco register acts only in hf mode
// - vco register holds bits 3..0 only
// - vco select uses same decode, zero bypasses
// - vco select resets to zero
// - registers take whole bytes, no bit access
//
// Decided for this implementation: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "amnc_map.svh"
module amnc_top
  import amnc_pkg::*;
(
  input wire logic hclk, // system clock
  input wire logic hresetn, // async reset, active low
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write when high
  input wire logic [2:0] hsize, // transfer size
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready
  output logic hreadyout, // slave ready
  output logic hresp, // always okay
  output logic [31:0] hrdata, // read data
  input wire logic am_if_amplifier, // raw am if amp output
  input wire logic low_band_vco, // raw low band vco amp output
  input wire logic high_frequency_mode, // hf mode active
  output amnc_pkg::amnc_hyst_e am_if_hysteresis_level, // buffer setting
  output amnc_pkg::amnc_hyst_e am_vco_hf_hysteresis_level, // buffer setting
  output logic if_frequency_counter, // filtered input to counter
  output logic low_band_vco_out // synchronised vco level
);
  import amnc_pkg::*;

  function automatic amnc_hyst_e hyst_decode(input logic [3:0] sel);
    if (sel[3]) hyst_decode = AMNC_WIDEST;
    else if (sel[2]) hyst_decode = AMNC_MIDDLE;
    else if (sel[1] || sel[0]) hyst_decode = AMNC_NARROW;
    else hyst_decode = AMNC_BYPASS;
  endfunction : hyst_decode

  function automatic logic hit(input logic [29:0] word, input logic [7:0] idx);
    hit = (word == {22'h000000, idx});
  endfunction : hit

  function automatic amnc_cyc_t ns2cyc(input int ns);
    int c;
    c = (ns * 1000 + `AMNC_CLK_PS - 1) / `AMNC_CLK_PS;
    if (c < 1) c = 1;
    ns2cyc = c[3:0];
  endfunction : ns2cyc

  // bus slave state
  logic wr_pend_r;
  logic wr_pend_nxt;
  logic [29:0] wr_word_r;
  logic [29:0] wr_word_nxt;
  logic [31:0] hrdata_r;
  logic [31:0] hrdata_nxt;
  logic hreadyout_r;
  logic hresp_r;
  logic [3:0] if_flt_r;
  logic [3:0] if_flt_nxt;
  logic [3:0] if_hys_r;
  logic [3:0] if_hys_nxt;
  logic [3:0] hf_hys_r;
  logic [3:0] hf_hys_nxt;
  logic addr_ok;
  logic [7:0] if_cfg_view;

  assign addr_ok = hsel && htrans[1] && hready;
  assign if_cfg_view = {if_flt_nxt, if_hys_nxt};

  // whole-byte register writes land in the data phase
  always_comb begin
    wr_pend_nxt = addr_ok && hwrite;
    wr_word_nxt = addr_ok ? haddr[31:2] : wr_word_r;
    if_flt_nxt = if_flt_r;
    if_hys_nxt = if_hys_r;
    hf_hys_nxt = hf_hys_r;
    if (wr_pend_r && hit(wr_word_r, `AMNC_IF_IDX)) begin
      if_flt_nxt = hwdata[`AMNC_FLT_MSB:`AMNC_FLT_LSB];
      if_hys_nxt = hwdata[`AMNC_HYS_MSB:`AMNC_HYS_LSB];
    end
    if (wr_pend_r && hit(wr_word_r, `AMNC_HF_IDX)) begin
      hf_hys_nxt = hwdata[`AMNC_HYS_MSB:`AMNC_HYS_LSB];
    end
  end

  // read data is forwarded from the next values so a read right
  // behind a write sees the new contents
  always_comb begin
    hrdata_nxt = hrdata_r;
    if (addr_ok && !hwrite) begin
      hrdata_nxt = 32'h00000000;
      if (hit(haddr[31:2], `AMNC_IF_IDX)) hrdata_nxt = {24'h000000, if_cfg_view};
      if (hit(haddr[31:2], `AMNC_HF_IDX)) hrdata_nxt = {28'h0000000, hf_hys_nxt};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_word_r <= 30'h00000000;
      hrdata_r <= 32'h00000000;
      hreadyout_r <= 1'b1;
      hresp_r <= 1'b0;
      if_flt_r <= `AMNC_FLT_RST;
      if_hys_r <= `AMNC_HYS_RST;
      hf_hys_r <= `AMNC_HYS_RST;
    end else begin
      wr_pend_r <= wr_pend_nxt;
      wr_word_r <= wr_word_nxt;
      hrdata_r <= hrdata_nxt;
      hreadyout_r <= 1'b1;
      hresp_r <= 1'b0;
      if_flt_r <= if_flt_nxt;
      if_hys_r <= if_hys_nxt;
      hf_hys_r <= hf_hys_nxt;
    end
  end

  assign hreadyout = hreadyout_r;
  assign hresp = hresp_r;
  assign hrdata = hrdata_r;

  // buffer settings
  amnc_hyst_e if_lvl_r;
  amnc_hyst_e if_lvl_nxt;
  amnc_hyst_e hf_lvl_r;
  amnc_hyst_e hf_lvl_nxt;

  always_comb begin
    if_lvl_nxt = hyst_decode(if_hys_r);
    // outside hf mode the vco path is left unconditioned
    hf_lvl_nxt = high_frequency_mode ? hyst_decode(hf_hys_r) : AMNC_BYPASS;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      if_lvl_r <= AMNC_BYPASS;
      hf_lvl_r <= AMNC_BYPASS;
    end else begin
      if_lvl_r <= if_lvl_nxt;
      hf_lvl_r <= hf_lvl_nxt;
    end
  end

  assign am_if_hysteresis_level = if_lvl_r;
  assign am_vco_hf_hysteresis_level = hf_lvl_r;

  // three-stage synchronisers; bit 0 am if, bit 1 vco
  logic [1:0] pin_in;
  logic [1:0] s1_r;
  logic [1:0] s2_r;
  logic [1:0] s3_r;
  logic [1:0] s1_nxt;
  logic [1:0] s2_nxt;
  logic [1:0] s3_nxt;

  assign pin_in = {low_band_vco, am_if_amplifier};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_sync
      always_comb begin
        s1_nxt[gi] = pin_in[gi];
        s2_nxt[gi] = s1_r[gi];
        s3_nxt[gi] = s2_r[gi];
      end
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          s1_r[gi] <= 1'b0;
          s2_r[gi] <= 1'b0;
          s3_r[gi] <= 1'b0;
        end else begin
          s1_r[gi] <= s1_nxt[gi];
          s2_r[gi] <= s2_nxt[gi];
          s3_r[gi] <= s3_nxt[gi];
        end
      end
    end
  endgenerate

  assign low_band_vco_out = s3_r[1];

  // minimum width from the number of set bits
  amnc_cyc_t min_cyc;
  always_comb begin
    unique case (4'(if_flt_r[0]) + 4'(if_flt_r[1]) + 4'(if_flt_r[2]) + 4'(if_flt_r[3]))
      4'h0: min_cyc = ns2cyc(`AMNC_FLT0_NS);
      4'h1: min_cyc = ns2cyc(`AMNC_FLT1_NS);
      4'h2: min_cyc = ns2cyc(`AMNC_FLT2_NS);
      4'h3: min_cyc = ns2cyc(`AMNC_FLT3_NS);
      default: min_cyc = ns2cyc(`AMNC_FLT4_NS);
    endcase
  end

  // shorter pulses are swallowed before the counter sees them
  amnc_pulse_filter u_flt (
    .hclk(hclk),
    .hresetn(hresetn),
    .din_agree(s2_r[0] == s3_r[0]),
    .din(s3_r[0]),
    .min_cycles(min_cyc),
    .dout_r(if_frequency_counter)
  );

  // checks
  logic rd_hf_a;
  assign rd_hf_a = addr_ok && !hwrite && hit(haddr[31:2], `AMNC_HF_IDX);

  property p_reset_vals;
    @(posedge hclk) disable iff (!hresetn)
    $rose(hresetn) |-> (if_flt_r == 4'h8) && (if_hys_r == 4'h0) && (hf_hys_r == 4'h0);
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("bad reset value");

  property p_if_write;
    @(posedge hclk) disable iff (!hresetn)
    (wr_pend_r && hit(wr_word_r, `AMNC_IF_IDX))
      |=> (if_flt_r == $past(hwdata[7:4])) && (if_hys_r == $past(hwdata[3:0]));
  endproperty
  a_if_write: assert property (p_if_write) else $error("if register write lost");

  property p_bypass;
    @(posedge hclk) disable iff (!hresetn)
    (if_hys_r == 4'h0) |=> (am_if_hysteresis_level == AMNC_BYPASS);
  endproperty
  a_bypass: assert property (p_bypass) else $error("if buffer not bypassed");

  property p_prio;
    @(posedge hclk) disable iff (!hresetn)
    (if_hys_r[3:2] == 2'b01) |=> (am_if_hysteresis_level == AMNC_MIDDLE);
  endproperty
  a_prio: assert property (p_prio) else $error("if priority decode wrong");

  property p_hf_off;
    @(posedge hclk) disable iff (!hresetn)
    !high_frequency_mode |=> (am_vco_hf_hysteresis_level == AMNC_BYPASS);
  endproperty
  a_hf_off: assert property (p_hf_off) else $error("vco conditioned outside hf");

  property p_hf_wide;
    @(posedge hclk) disable iff (!hresetn)
    (high_frequency_mode && hf_hys_r[3]) |=> (am_vco_hf_hysteresis_level == AMNC_WIDEST);
  endproperty
  a_hf_wide: assert property (p_hf_wide) else $error("vco decode wrong");

  property p_hf_read;
    @(posedge hclk) disable iff (!hresetn)
    rd_hf_a |=> (hrdata[31:4] == 28'h0000000);
  endproperty
  a_hf_read: assert property (p_hf_read) else $error("vco upper bits not zero");

  property p_flt_long;
    @(posedge hclk) disable iff (!hresetn)
    ($changed(if_frequency_counter) && $past(if_flt_r == 4'hf, 1) && $past(if_flt_r == 4'hf, 8))
      |-> ($past(s3_r[0], 1) == if_frequency_counter)
          && ($past(s3_r[0], 8) == if_frequency_counter);
  endproperty
  a_flt_long: assert property (p_flt_long) else $error("short pulse passed");

  property p_bus_ok;
    @(posedge hclk) disable iff (!hresetn)
    hreadyout && !hresp;
  endproperty
  a_bus_ok: assert property (p_bus_ok) else $error("bus answer not okay ready");

  property p_cv_write;
    @(posedge hclk) disable iff (!hresetn)
    wr_pend_r && hit(wr_word_r, `AMNC_IF_IDX);
  endproperty
  c_cv_write: cover property (p_cv_write);

  property p_cv_pass;
    @(posedge hclk) disable iff (!hresetn)
    $rose(if_frequency_counter);
  endproperty
  c_cv_pass: cover property (p_cv_pass);

  property p_cv_hf;
    @(posedge hclk) disable iff (!hresetn)
    am_vco_hf_hysteresis_level == AMNC_WIDEST;
  endproperty
  c_cv_hf: cover property (p_cv_hf);
endmodule : amnc_top

/* src/amnc_map.svh */
`ifndef AMNC_MAP_SVH
`define AMNC_MAP_SVH
// register indices; byte address is four times the index
`define AMNC_IF_IDX 8'heb
`define AMNC_HF_IDX 8'hee
// field positions
`define AMNC_FLT_MSB 7
`define AMNC_FLT_LSB 4
`define AMNC_HYS_MSB 3
`define AMNC_HYS_LSB 0
// reset values
`define AMNC_FLT_RST 4'h8
`define AMNC_HYS_RST 4'h0
// timing
`define AMNC_CLK_PS 10000
`define AMNC_FLT0_NS 5
`define AMNC_FLT1_NS 20
`define AMNC_FLT2_NS 40
`define AMNC_FLT3_NS 60
`define AMNC_FLT4_NS 80
`endif

/* src/amnc_pkg.sv */
package amnc_pkg;
  typedef enum logic [1:0] {
    AMNC_BYPASS = 2'b00,
    AMNC_NARROW = 2'b01,
    AMNC_MIDDLE = 2'b10,
    AMNC_WIDEST = 2'b11
  } amnc_hyst_e;
  typedef logic [3:0] amnc_cyc_t;
endpackage : amnc_pkg

/* src/amnc_pulse_filter.sv */
`timescale 1ns/1ps
module amnc_pulse_filter
  import amnc_pkg::*;
(
  input wire logic hclk, // system clock
  input wire logic hresetn, // async reset, active low
  input wire logic din_agree, // last two sync stages agree
  input wire logic din, // synchronised level
  input wire amnc_pkg::amnc_cyc_t min_cycles, // required persistence
  output logic dout_r // qualified level
);
  import amnc_pkg::*;

  amnc_cyc_t cnt_r;
  amnc_cyc_t cnt_nxt;
  logic dout_nxt;

  // a level only passes after it persisted min_cycles samples
  always_comb begin
    cnt_nxt = '0;
    dout_nxt = dout_r;
    if (din_agree && (din != dout_r)) begin
      cnt_nxt = cnt_r + 4'h1;
      if (cnt_nxt >= min_cycles) begin
        dout_nxt = din;
        cnt_nxt = '0;
      end
    end else if (din != dout_r) begin
      // stages disagree: hold the count, the change is not yet real
      cnt_nxt = cnt_r;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r <= 4'h0;
      dout_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      dout_r <= dout_nxt;
    end
  end
endmodule : amnc_pulse_filter

/* tb/amnc_amp_model.sv */
`timescale 1ns/1ps
module amnc_amp_model (
  input wire logic hclk, // system clock
  input wire logic hresetn, // async reset, active low
  input wire logic go, // start one if pulse
  input wire logic [7:0] len, // pulse length in cycles
  input wire logic vco_lvl, // level asked of the vco amp
  output logic am_if_amplifier, // if amp output
  output logic low_band_vco // vco amp output
);
  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  always_comb begin
    cnt_nxt = cnt_r;
    if (go) begin
      cnt_nxt = len;
    end else if (cnt_r != 8'h00) begin
      cnt_nxt = cnt_r - 8'h01;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r <= 8'h00;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end
  // the amp drives its output all the time; high exactly len cycles per pulse
  assign am_if_amplifier = (cnt_r != 8'h00);
  assign low_band_vco = vco_lvl;
endmodule : amnc_amp_model

/* tb/amnc_top_tb.sv */
`timescale 1ns/1ps
`include "amnc_map.svh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED %s exp=%h got=%h", nm, e, g); end end
module amnc_top_tb;
  import amnc_pkg::*;
  localparam logic [31:0] IF_A = {22'h0, `AMNC_IF_IDX, 2'b00};
  localparam logic [31:0] HF_A = {22'h0, `AMNC_HF_IDX, 2'b00};
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, am_if, vco, hf_mode;
  logic go, vco_lvl, if_frequency_counter, low_band_vco_out, seen;
  logic [31:0] haddr, hwdata, hrdata, d;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] len;
  amnc_hyst_e am_if_hysteresis_level, am_vco_hf_hysteresis_level;
  int n_mismatch, n_checks;
  logic [3:0] hc [8] = '{4'h8, 4'hf, 4'h4, 4'h7, 4'h2, 4'h3, 4'h1, 4'h0};
  amnc_hyst_e he [8] = '{AMNC_WIDEST, AMNC_WIDEST, AMNC_MIDDLE, AMNC_MIDDLE,
    AMNC_NARROW, AMNC_NARROW, AMNC_NARROW, AMNC_BYPASS};
  logic [3:0] fv [5] = '{4'h0, 4'h1, 4'h5, 4'hb, 4'hf};
  int ncy [5] = '{1, 2, 4, 6, 8};
  assign hready = hreadyout;
  amnc_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .am_if_amplifier(am_if),
    .low_band_vco(vco), .high_frequency_mode(hf_mode),
    .am_if_hysteresis_level(am_if_hysteresis_level),
    .am_vco_hf_hysteresis_level(am_vco_hf_hysteresis_level),
    .if_frequency_counter(if_frequency_counter), .low_band_vco_out(low_band_vco_out));
  amnc_amp_model u_amp (.hclk(hclk), .hresetn(hresetn), .go(go), .len(len),
    .vco_lvl(vco_lvl), .am_if_amplifier(am_if), .low_band_vco(vco));
  always #5 hclk = ~hclk;
  task final_report;
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : final_report
  task automatic wait_rdy;
    int i;
    for (i = 0; i < 50; i++) begin
      @(posedge hclk);
      if (hready === 1'b1) break;
    end
    if (i == 50) begin
      n_mismatch++;
      final_report;
    end
  endtask : wait_rdy
  // one single transfer; read data taken at the edge closing the data phase
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [2:0] sz,
                      input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    hsize <= sz;
    htrans <= 2'b10;
    wait_rdy;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy;
    rd = hrdata;
    `CHK("hresp", 1'b0, hresp)
  endtask : xfer
  task automatic pulse(input int n, output logic s);
    len <= n[7:0];
    go <= 1'b1;
    @(posedge hclk);
    go <= 1'b0;
    s = 1'b0;
    repeat (30) begin
      @(posedge hclk);
      s = s | (if_frequency_counter === 1'b1);
    end
  endtask : pulse
  initial begin
    hclk = 0;
    hresetn = 0;
    hsel = 0;
    haddr = 0;
    htrans = 0;
    hwrite = 0;
    hsize = 3'b010;
    hwdata = 0;
    hf_mode = 1;
    go = 0;
    len = 0;
    vco_lvl = 0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    `CHK("if_level", AMNC_BYPASS, am_if_hysteresis_level)
    `CHK("hf_level", AMNC_BYPASS, am_vco_hf_hysteresis_level)
    xfer(1'b0, IF_A, 3'b010, 32'h0, d);
    `CHK("if_cfg", 32'h80, d)
    xfer(1'b0, HF_A, 3'b010, 32'h0, d);
    `CHK("hf_cfg", 32'h0, d)
    for (int i = 0; i < 8; i++) begin
      xfer(1'b1, IF_A, 3'b010, {24'h0, 4'ha, hc[i]}, d);
      xfer(1'b1, HF_A, 3'b010, {28'hfffffff, hc[i]}, d);
      repeat (3) @(posedge hclk);
      `CHK("if_level", he[i], am_if_hysteresis_level)
      `CHK("hf_level", he[i], am_vco_hf_hysteresis_level)
      xfer(1'b0, IF_A, 3'b010, 32'h0, d);
      `CHK("if_cfg", {24'h0, 4'ha, hc[i]}, d)
      xfer(1'b0, HF_A, 3'b010, 32'h0, d);
      `CHK("hf_cfg", {28'h0, hc[i]}, d)
    end
    xfer(1'b1, HF_A, 3'b010, 32'h6, d);
    hf_mode <= 1'b0;
    repeat (3) @(posedge hclk);
    `CHK("hf_off", AMNC_BYPASS, am_vco_hf_hysteresis_level)
    xfer(1'b1, IF_A, 3'b000, 32'h123456c5, d);
    xfer(1'b1, 32'h3b0, 3'b010, 32'h5a, d);
    xfer(1'b0, 32'h3b0, 3'b010, 32'h0, d);
    `CHK("unmapped", 32'h0, d)
    xfer(1'b0, IF_A, 3'b010, 32'h0, d);
    `CHK("byte_wr", 32'hc5, d)
    for (int i = 0; i < 5; i++) begin
      xfer(1'b1, IF_A, 3'b010, {24'h0, fv[i], 4'h0}, d);
      if (ncy[i] > 1) begin
        pulse(ncy[i] - 1, seen);
        `CHK("short_pulse", 1'b0, seen)
      end
      pulse(ncy[i] + 1, seen);
      `CHK("long_pulse", 1'b1, seen)
    end
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    xfer(1'b0, IF_A, 3'b010, 32'h0, d);
    `CHK("if_cfg_rst", 32'h80, d)
    xfer(1'b0, HF_A, 3'b010, 32'h0, d);
    `CHK("hf_cfg_rst", 32'h0, d)
    vco_lvl <= 1'b1;
    repeat (6) @(posedge hclk);
    `CHK("vco_out", 1'b1, low_band_vco_out)
    final_report;
  end
endmodule : amnc_top_tb
